// ### design/adc_readout_params.svh
// Constants for the group-sampling parallel readout block
`ifndef ADC_READOUT_PARAMS_SVH
`define ADC_READOUT_PARAMS_SVH
`define RESULT_BITS 18
`define CHANNEL_COUNT 8
`define CONV_TIME_NS 2000
`define REF_CLK_PERIOD_NS 8
`define WORD_XFERS 2
`define BYTE_XFERS 3
`define WORD_FIRST_FLAG_XFERS 2
`define BYTE_FIRST_FLAG_XFERS 3
`define MODE_WORD 2'b00
`define MODE_BYTE 2'b01
`define MODE_SERIAL 2'b10
`endif

// ### design/adc_readout_pkg.sv
// Types shared by the group-sampling readout block
`default_nettype none
`include "adc_readout_params.svh"
package adc_readout_pkg;
  typedef enum logic [1:0] {
    IDLE_ST = 2'b00,
    ARMED_ST = 2'b01,
    CONVERT_ST = 2'b10
  } conv_state_e;
  typedef struct packed {
    logic cs_n;
    logic rd_n;
  } strobe_s;
  typedef struct packed {
    logic [15:0] data;
    logic [15:0] data_oe_n;
    logic flag;
    logic flag_oe_n;
  } bus_out_s;
endpackage
`default_nettype wire

// ### design/edge_sync.sv
// Two-flop synchroniser with rising and falling edge pulses
`timescale 1ns/1ps
`default_nettype none
module edge_sync #(
  parameter logic RESET_LEVEL = 1'b0
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Pin and results
  input wire logic pin,
  output logic level,
  output logic rise,
  output logic fall
);
  logic meta_q;
  logic sync_q;
  logic last_q;
  // Only sync_q and later look at the synchronised level
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_q <= RESET_LEVEL;
      sync_q <= RESET_LEVEL;
      last_q <= RESET_LEVEL;
    end else begin
      meta_q <= pin;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end
  // Edge detection on the settled level
  assign level = sync_q;
  assign rise = sync_q & ~last_q;
  assign fall = ~sync_q & last_q;
endmodule
`default_nettype wire

// ### design/conversion_timer.sv
// Fixed conversion timer raising busy for the conversion time
`timescale 1ns/1ps
`default_nettype none
`include "adc_readout_params.svh"
module conversion_timer #(
  parameter int CONV_CYCLES = `CONV_TIME_NS / `REF_CLK_PERIOD_NS
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Control
  input wire logic start,
  output logic busy,
  output logic done
);
  localparam int CW = $clog2(CONV_CYCLES + 1);
  logic [CW-1:0] count_q;
  initial begin
    if (CONV_CYCLES < 1) $error("CONV_CYCLES must be at least one");
  end
  // Down counter; done pulses as busy drops
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      count_q <= '0;
    end else if (start && count_q == '0) begin
      count_q <= CW'(CONV_CYCLES);
    end else if (count_q != '0) begin
      count_q <= count_q - 1'b1;
    end
  end
  assign busy = (count_q != '0);
  assign done = (count_q == CW'(1));
endmodule
`default_nettype wire

// ### design/adc_group_readout.sv
// Group sampling control and parallel word/byte result readout
`timescale 1ns/1ps
`default_nettype none
`include "adc_readout_params.svh"
module adc_group_readout
  import adc_readout_pkg::*;
#(
  parameter int CHANNELS = `CHANNEL_COUNT,
  parameter int RES_BITS = `RESULT_BITS,
  parameter int CONV_TIME_NS = `CONV_TIME_NS
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Sample starts (pins)
  input wire logic group_a_sample_start,
  input wire logic group_b_sample_start,
  // Converter core results, one word per channel
  input wire logic [CHANNELS*RES_BITS-1:0] core_results,
  // Interface select pins
  input wire logic interface_select,
  input wire logic byte_serial_select,
  input wire logic byte_order_select,
  // Host strobes (pins)
  input wire logic cs_n,
  input wire logic rd_n,
  // Status
  output logic busy,
  output logic serial_mode,
  // Output bus and first-channel flag, low enable drives
  output logic [15:0] output_bus_o,
  output logic [15:0] output_bus_oe_n,
  output logic first_channel_flag_o,
  output logic first_channel_flag_oe_n
);
  localparam int CONV_CYCLES = (CONV_TIME_NS + `REF_CLK_PERIOD_NS - 1) / `REF_CLK_PERIOD_NS;
  localparam int CHW = $clog2(CHANNELS);

  initial begin
    if (CHANNELS != `CHANNEL_COUNT) $error("CHANNELS must be eight");
    if (RES_BITS != `RESULT_BITS) $error("RES_BITS must be eighteen");
    if (CONV_CYCLES < 1) $error("conversion time too short");
  end

  // Synchronised pins
  logic a_rise, b_rise;
  logic cs_level, cs_fall, cs_rise;
  logic rd_level, rd_fall, rd_rise;
  strobe_s strobe;

  edge_sync #(.RESET_LEVEL(1'b0)) sync_a (.ref_clk(ref_clk), .reset_n(reset_n),
    .pin(group_a_sample_start), .level(), .rise(a_rise), .fall());
  edge_sync #(.RESET_LEVEL(1'b0)) sync_b (.ref_clk(ref_clk), .reset_n(reset_n),
    .pin(group_b_sample_start), .level(), .rise(b_rise), .fall());
  edge_sync #(.RESET_LEVEL(1'b1)) sync_cs (.ref_clk(ref_clk), .reset_n(reset_n),
    .pin(cs_n), .level(cs_level), .rise(cs_rise), .fall(cs_fall));
  edge_sync #(.RESET_LEVEL(1'b1)) sync_rd (.ref_clk(ref_clk), .reset_n(reset_n),
    .pin(rd_n), .level(rd_level), .rise(rd_rise), .fall(rd_fall));

  assign strobe.cs_n = cs_level;
  assign strobe.rd_n = rd_level;

  // Mode decode
  // mode select decode
  function automatic logic [1:0] decode_mode(input logic par_sel, input logic bs_sel);
    if (!par_sel) begin
      decode_mode = `MODE_WORD;
    end else if (bs_sel) begin
      decode_mode = `MODE_BYTE;
    end else begin
      decode_mode = `MODE_SERIAL;
    end
  endfunction
  wire [1:0] mode = decode_mode(interface_select, byte_serial_select);
  wire word_mode = (mode == `MODE_WORD);
  wire byte_mode = (mode == `MODE_BYTE);
  assign serial_mode = (mode == `MODE_SERIAL);

  // Sampling state
  conv_state_e state_q, state_d;
  logic a_held_q, b_held_q;
  logic conv_start, conv_done;

  // group A hold, waits for B
  // group B hold
  // Hold flags: an edge in the start cycle still counts (set wins)
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      a_held_q <= 1'b0;
      b_held_q <= 1'b0;
    end else begin
      a_held_q <= (a_held_q & ~conv_start) | (a_rise & (state_q != CONVERT_ST));
      b_held_q <= (b_held_q & ~conv_start) | (b_rise & (state_q != CONVERT_ST));
    end
  end

  wire both_held = a_held_q & b_held_q;
  assign conv_start = both_held & (state_q != CONVERT_ST);
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      IDLE_ST: begin
        // Both edges seen together go straight to converting
        if (both_held) state_d = CONVERT_ST;
        else if (a_held_q | b_held_q) state_d = ARMED_ST;
      end
      ARMED_ST: begin
        if (both_held) state_d = CONVERT_ST;
      end
      CONVERT_ST: begin
        if (conv_done) state_d = IDLE_ST;
      end
      default: state_d = IDLE_ST;
    endcase
  end
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= IDLE_ST;
    end else begin
      state_q <= state_d;
    end
  end

  conversion_timer #(.CONV_CYCLES(CONV_CYCLES)) timer (.ref_clk(ref_clk), .reset_n(reset_n),
    .start(conv_start), .busy(busy), .done(conv_done));

  // load output registers at busy fall
  // reads see old values until then
  logic [RES_BITS-1:0] result_q [CHANNELS];
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < CHANNELS; i++) result_q[i] <= '0;
    end else if (conv_done) begin
      for (int i = 0; i < CHANNELS; i++) result_q[i] <= core_results[i*RES_BITS +: RES_BITS];
    end
  end

  // Readout pointers
  logic [CHW-1:0] chan_q;
  logic [1:0] xfer_q;
  logic [4:0] fall_count_q;
  logic active_q;
  wire [1:0] last_xfer = byte_mode ? 2'(`BYTE_XFERS - 1) : 2'(`WORD_XFERS - 1);

  // three byte transfers per channel
  // Rewind on fresh results, or when chip select moves without read (separate
  // strobes). Tied strobes move both at once, so the pointer runs on from pulse
  // to pulse; the cost is that a tied-strobe host cannot restart mid-sequence.
  wire frame_reset = conv_done | (cs_fall & ~rd_fall) | (cs_rise & ~rd_rise);
  // Pointer advances after each read rise, so the next fall shows the next item
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      chan_q <= '0;
      xfer_q <= '0;
      fall_count_q <= '0;
    end else if (frame_reset) begin
      chan_q <= '0;
      xfer_q <= '0;
      fall_count_q <= '0;
    end else if (rd_rise && !serial_mode) begin
      if (xfer_q == last_xfer) begin
        xfer_q <= '0;
        chan_q <= chan_q + 1'b1;
      end else begin
        xfer_q <= xfer_q + 1'b1;
      end
    end else if (rd_fall && fall_count_q != 5'h1F) begin
      fall_count_q <= fall_count_q + 5'h01;
    end
  end

  // bus leaves float on combined strobe fall
  // chip select fall enables byte lanes
  // float again when frame ends
  // Tied strobes: cs and rd fall together, both open the bus
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      active_q <= 1'b0;
    end else if (strobe.cs_n || serial_mode) begin
      active_q <= 1'b0;
    end else if (cs_fall || rd_fall) begin
      active_q <= 1'b1;
    end
  end

  // Output word selection
  wire [RES_BITS-1:0] cur = result_q[chan_q];
  // pad to 24 bits with low zeros
  wire [23:0] padded = {cur, 6'h00};
  wire [1:0] byte_idx = byte_order_select ? xfer_q : 2'(`BYTE_XFERS - 1) - xfer_q;
  wire [7:0] byte_val = (byte_idx == 2'h0) ? padded[23:16] :
                        (byte_idx == 2'h1) ? padded[15:8] : padded[7:0];
  // upper 16 then low two on top
  wire [15:0] word_val = (xfer_q == 2'h0) ? cur[17:2] : {cur[1:0], 14'h0000};
  wire [15:0] bus_val = byte_mode ? {8'h00, byte_val} : word_val;

  // word flag clears at third fall
  // byte flag clears at fourth fall
  wire [4:0] flag_limit = byte_mode ? 5'(`BYTE_FIRST_FLAG_XFERS) : 5'(`WORD_FIRST_FLAG_XFERS);
  wire flag_val = (fall_count_q != 5'h00) && (fall_count_q <= flag_limit);

  // Registered data outputs
  bus_out_s out_q;
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      out_q <= '{data: 16'h0000, data_oe_n: 16'hFFFF, flag: 1'b0, flag_oe_n: 1'b1};
    end else begin
      out_q.data <= bus_val;
      out_q.data_oe_n <= !active_q ? 16'hFFFF : (byte_mode ? 16'hFF00 : 16'h0000);
      out_q.flag <= flag_val;
      out_q.flag_oe_n <= ~active_q;
    end
  end
  assign output_bus_o = out_q.data;
  assign output_bus_oe_n = out_q.data_oe_n;
  assign first_channel_flag_o = out_q.flag;
  assign first_channel_flag_oe_n = out_q.flag_oe_n;

  // Checks
  // busy length
  busy_len_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    $rose(busy) |-> busy [*8]) else $error("busy shorter than conversion");
  busy_start_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    conv_start |=> busy) else $error("busy did not rise after both starts");
  a_only_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    conv_start |-> a_held_q && b_held_q) else $error("conversion without both groups");
  load_at_fall_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    conv_done |=> result_q[0] == $past(core_results[RES_BITS-1:0])) else $error("no load");
  hold_busy_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    busy && !conv_done |=> $stable(result_q[0])) else $error("results changed mid conversion");
  float_idle_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    strobe.cs_n |-> ##2 output_bus_oe_n == 16'hFFFF && first_channel_flag_oe_n)
    else $error("bus driven outside frame");
  byte_lanes_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    byte_mode && $stable(byte_mode) |=> output_bus_oe_n[15:8] == 8'hFF)
    else $error("upper lanes driven in byte mode");
  frame_restart_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    cs_fall && !rd_fall |=> chan_q == '0 && xfer_q == '0) else $error("pointer not reset");
  word_low_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    word_mode && xfer_q == 2'h1 |-> bus_val[13:0] == 14'h0000) else $error("low bits not zero");
  flag_drop_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    word_mode && fall_count_q >= 5'h03 |-> !flag_val) else $error("flag stayed high");
  // Readout side: flags, pointers and float; also busy against the conversion state
  // byte flag low from fourth fall
  byte_flag_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    byte_mode && fall_count_q >= 5'h04 |-> !flag_val)
    else $error("byte flag stayed high");
  busy_state_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    busy |-> state_q == CONVERT_ST) else $error("busy outside conversion state");
  seq_reset_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    conv_done |=> chan_q == '0 && xfer_q == '0 && fall_count_q == '0)
    else $error("pointers not rewound after conversion");
  chan_step_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    rd_rise && !frame_reset && !serial_mode && xfer_q == last_xfer
    |=> chan_q == $past(chan_q) + 1'b1) else $error("channel did not advance");
  serial_float_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    serial_mode |-> ##2 output_bus_oe_n == 16'hFFFF) else $error("bus driven in serial mode");

  word_read_c: cover property (@(posedge ref_clk) word_mode && rd_fall && active_q);
  byte_read_c: cover property (@(posedge ref_clk) byte_mode && rd_fall && active_q);
  split_start_c: cover property (@(posedge ref_clk) a_rise ##[1:20] b_rise);
  read_busy_c: cover property (@(posedge ref_clk) busy && rd_fall);
  tied_read_c: cover property (@(posedge ref_clk) word_mode && cs_fall && rd_fall);
endmodule
`default_nettype wire

// ### testbench/host_reader.sv
// Host controller model strobing chip select and read
`timescale 1ns/1ps
`default_nettype none
module host_reader (
  // Clock
  input wire logic ref_clk,
  // Strobes to the device
  output logic cs_n,
  output logic rd_n,
  // Bus and flag from the device
  input wire logic [15:0] bus_o,
  input wire logic [15:0] bus_oe_n,
  input wire logic flag_o,
  input wire logic flag_oe_n
);
  // Both strobes released while idle
  initial begin
    cs_n = 1'b1;
    rd_n = 1'b1;
  end
  task automatic open_frame();
    @(posedge ref_clk);
    #1 cs_n = 1'b0;
    repeat (4) @(posedge ref_clk);
  endtask
  // one item per read pulse; long pulses survive the synchroniser
  task automatic xfer(output logic [15:0] d, output logic [15:0] oe, output logic f);
    #1 rd_n = 1'b0;
    repeat (8) @(posedge ref_clk);
    #1;
    // Released lines read as the inverse, so a float never passes
    d = bus_o ^ bus_oe_n;
    oe = bus_oe_n;
    f = flag_o ^ flag_oe_n;
    rd_n = 1'b1;
    repeat (8) @(posedge ref_clk);
  endtask
  task automatic close_frame();
    #1 cs_n = 1'b1;
    repeat (8) @(posedge ref_clk);
    #1;
  endtask
  task automatic tied_xfer(output logic [15:0] d, output logic [15:0] oe, output logic f);
    @(posedge ref_clk);
    #1 cs_n = 1'b0;
    rd_n = 1'b0;
    repeat (8) @(posedge ref_clk);
    #1;
    d = bus_o ^ bus_oe_n;
    oe = bus_oe_n;
    f = flag_o ^ flag_oe_n;
    cs_n = 1'b1;
    rd_n = 1'b1;
    repeat (8) @(posedge ref_clk);
  endtask
endmodule
`default_nettype wire

// ### testbench/test_adc_group_readout.sv
// Self-checking bench for group sampling and word/byte readout
`timescale 1ns/1ps
`default_nettype none
module test_adc_group_readout;
  localparam int CONV_NS = 800;
  localparam int CONV_CYC = CONV_NS / 8;
  // Row: select pins and transfers per channel, 0 for serial
  typedef struct packed {logic isel; logic bsel; logic bord; logic [1:0] nx;} row_s;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic start_a = 1'b0, start_b = 1'b0;
  logic [143:0] core_results = '0;
  logic isel = 1'b0, bsel = 1'b1, bord = 1'b1;
  logic cs_n, rd_n, busy, serial_mode, flag_o, flag_oe_n, f;
  logic [15:0] bus_o, bus_oe_n, d, oe;
  int errors = 0;
  int samples_checked = 0;
  int busy_len = 0, last_len = 0;
  row_s rows [4] = '{'{0, 1, 1, 2}, '{1, 1, 1, 3}, '{1, 1, 0, 3}, '{1, 0, 1, 0}};

  // Free-running clock
  always #4 ref_clk = ~ref_clk;

  adc_group_readout #(.CONV_TIME_NS(CONV_NS)) u_dut (
    .ref_clk(ref_clk), .reset_n(reset_n),
    .group_a_sample_start(start_a), .group_b_sample_start(start_b),
    .core_results(core_results), .interface_select(isel),
    .byte_serial_select(bsel), .byte_order_select(bord),
    .cs_n(cs_n), .rd_n(rd_n), .busy(busy), .serial_mode(serial_mode),
    .output_bus_o(bus_o), .output_bus_oe_n(bus_oe_n),
    .first_channel_flag_o(flag_o), .first_channel_flag_oe_n(flag_oe_n));

  host_reader u_host (
    .ref_clk(ref_clk), .cs_n(cs_n), .rd_n(rd_n), .bus_o(bus_o),
    .bus_oe_n(bus_oe_n), .flag_o(flag_o), .flag_oe_n(flag_oe_n));

  // Busy length measured independently of the tests
  always @(posedge ref_clk) begin
    if (busy === 1'b1) begin
      busy_len <= busy_len + 1;
    end else if (busy_len != 0) begin
      last_len <= busy_len;
      busy_len <= 0;
    end
  end

  // Result set s; channel 0 of set 0 is 34567h, a handy byte pattern
  function automatic logic [17:0] res(int s, int c);
    return 18'(32'h34567 + c * 32'h1357 + s * 32'h2AAAA);
  endfunction

  // Expected item k of channel c, zero padded to 24 bits
  function automatic logic [15:0] want(int s, int c, int k, row_s r);
    logic [23:0] p;
    p = {res(s, c), 6'h00};
    if (r.nx == 2)
      return k == 0 ? p[23:8] : {p[7:6], 14'h0000};
    return {8'h00, p[8 * (r.bord ? 2 - k : k) +: 8]};
  endfunction

  task automatic chk(string n, logic [17:0] e, logic [17:0] g);
    samples_checked++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic end_sim();
    if (errors == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic convert(int s);
    int n = 0;
    for (int c = 0; c < 8; c++) core_results[c * 18 +: 18] = res(s, c);
    start_a = 1'b1;
    repeat (4) @(posedge ref_clk);
    #1 start_a = 1'b0;
    repeat (20) @(posedge ref_clk);
    #1 chk("busy_a_only", 18'h0, busy);
    start_b = 1'b1;
    while (busy !== 1'b1 && n < 20) begin
      @(posedge ref_clk);
      #1 n++;
    end
    chk("busy_rise", 18'h1, busy);
    start_b = 1'b0;
  endtask

  task automatic wait_done();
    int n = 0;
    while (busy !== 1'b0 && n < 300) begin
      @(posedge ref_clk);
      #1 n++;
    end
    repeat (2) @(posedge ref_clk);
    #1 chk("busy_end", 18'h0, busy);
    chk("busy_len", 18'(CONV_CYC), 18'(last_len));
  endtask

  task automatic frame(row_s r, int s, int nch);
    u_host.open_frame();
    for (int t = 0; t < (r.nx == 0 ? 1 : nch * r.nx); t++) begin
      u_host.xfer(d, oe, f);
      if (r.nx == 0) begin
        chk("serial_float", 18'hFFFF, oe);
        chk("serial_mode", 18'h1, serial_mode);
      end else begin
        chk("bus_oe", r.nx == 2 ? 18'h0 : 18'hFF00, oe);
        chk("data", want(s, t / r.nx, t % r.nx, r),
            r.nx == 2 ? d : d[7:0]);
        chk("first_flag", 18'(t < r.nx), f);
      end
    end
    u_host.close_frame();
    chk("bus_float", 18'hFFFF, bus_oe_n);
    chk("flag_float", 18'h1, flag_oe_n);
  endtask

  // Reset, row loop over all modes, then read during and after busy
  initial begin
    repeat (2) @(posedge ref_clk);
    #1 chk("reset_oe", 18'hFFFF, bus_oe_n);
    chk("reset_busy", 18'h0, busy);
    reset_n = 1'b1;
    repeat (2) @(posedge ref_clk);
    #1 convert(0);
    wait_done();
    foreach (rows[i]) begin
      isel = rows[i].isel;
      bsel = rows[i].bsel;
      bord = rows[i].bord;
      frame(rows[i], 0, 8);
    end
    isel = 1'b0;
    bsel = 1'b1;
    convert(1);
    frame(rows[0], 0, 1);
    wait_done();
    frame(rows[0], 1, 1);
    // Tied strobes: pointer runs on across pulses, bus floats between them
    for (int t = 0; t < 4; t++) begin
      u_host.tied_xfer(d, oe, f);
      chk("tied_oe", 18'h0, oe);
      chk("tied_data", want(1, t / 2, t % 2, rows[0]), d);
      chk("tied_flag", 18'(t < 2), f);
      chk("tied_float", 18'hFFFF, bus_oe_n);
    end
    end_sim();
  end

  // Watchdog well beyond the expected run length
  initial begin
    #100000;
    errors++;
    end_sim();
  end
endmodule
`default_nettype wire
